/* src/timer_pkg.sv */
// shared constants for the standard timer pair
package timer_pkg;
  // operating mode field codes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  // output control in compare mode
  localparam logic [1:0] IO_NONE   = 2'h0;
  localparam logic [1:0] IO_LOW    = 2'h1;
  localparam logic [1:0] IO_HIGH   = 2'h2;
  localparam logic [1:0] IO_TOGGLE = 2'h3;
  // output control in pwm / single pulse mode
  localparam logic [1:0] PWM_FORCE_LOW  = 2'h0;
  localparam logic [1:0] PWM_FORCE_HIGH = 2'h1;
  localparam logic [1:0] PWM_WAVE       = 2'h2;
  localparam logic [1:0] PWM_SINGLE     = 2'h3;
  // output control in capture mode
  localparam logic [1:0] CAP_RISE = 2'h0;
  localparam logic [1:0] CAP_FALL = 2'h1;
  localparam logic [1:0] CAP_BOTH = 2'h2;
  localparam logic [1:0] CAP_OFF  = 2'h3;
  // tick divider
  localparam int         DIV_W       = 6;
  localparam logic [1:0] DIV_SEL_1   = 2'h0;
  localparam logic [1:0] DIV_SEL_4   = 2'h1;
  localparam logic [1:0] DIV_SEL_16  = 2'h2;
  localparam logic [5:0] DIV_MASK_1  = 6'h00;
  localparam logic [5:0] DIV_MASK_4  = 6'h03;
  localparam logic [5:0] DIV_MASK_16 = 6'h0f;
  localparam logic [5:0] DIV_MASK_64 = 6'h3f;
  localparam logic [5:0] DIV_STEP    = 6'h01;
  // instance sizes: counter width and comparator p width
  localparam int CNT_W0 = 10;
  localparam int PW0    = 3;
  localparam int CNT_W1 = 16;
  localparam int PW1    = 8;
endpackage

/* src/edge_if.sv */
// edge detector carrier between the timer core and its pin samplers
`timescale 1ns/1ps
`default_nettype none
interface edge_if;
  logic pin_in;
  logic rise;
  logic fall;
  modport det (input pin_in, output rise, output fall);
  modport user (output pin_in, input rise, input fall);
endinterface
`default_nettype wire

/* src/pin_edge_sync.sv */
// two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // pin and edges
  edge_if.det       e
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // meta_q feeds sync_q only; edges look at later stages
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= e.pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // consecutive sample compare
  assign e.rise = sync_q & ~prev_q;
  assign e.fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

/* src/timer_pulse_capture_modes.sv */
// standard timer pair: pwm, single pulse, capture, compare and timer modes
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// timer core
// ----------------------------------------------------------------------
module timer_core #(
  parameter int CNT_W = 10,
  parameter int PW    = 3
) (
  // clock, reset, tick
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             tick,
  // control bits
  input  wire logic             mode_sel_hi,
  input  wire logic             mode_sel_lo,
  input  wire logic             out_ctrl_hi,
  input  wire logic             out_ctrl_lo,
  input  wire logic             clear_source_sel,
  input  wire logic             duty_period_swap,
  input  wire logic             out_initial_level,
  input  wire logic             out_polarity,
  // run bit write
  input  wire logic             run_wr,
  input  wire logic             run_wdata,
  // comparator values
  input  wire logic             a_wr,
  input  wire logic [CNT_W-1:0] a_wdata,
  input  wire logic [PW-1:0]    compare_p_value,
  // flag clears
  input  wire logic             flag_a_clr,
  input  wire logic             flag_p_clr,
  // pins
  input  wire logic             ext_trigger_pin,
  input  wire logic             capture_in_pin,
  output logic                  timer_out_pin,
  output logic                  timer_out_oe,
  // status
  output logic                  counter_run,
  output logic [CNT_W-1:0]      compare_a_value,
  output logic [CNT_W-1:0]      count_value,
  output logic                  cmp_a_irq_flag,
  output logic                  cmp_p_irq_flag
);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  // comparator p compares the top bits of the counter
  function automatic logic [CNT_W-1:0] p_full(input logic [PW-1:0] p);
    return {p, {(CNT_W-PW){1'b0}}};
  endfunction

  logic [1:0]       mode;
  logic [1:0]       io;
  logic             sp_mode, pwm_mode, cap_mode, cmp_mode;
  logic             run_q, run_prev_q, run_rise;
  logic [CNT_W-1:0] cnt_q, compare_a_value_q, cnt_inc;
  logic             a_match, p_match, clr_now, cap_evt, duty_act;
  logic             flag_a_q, flag_p_q, set_a, set_p;
  logic             lvl_q, lvl_d, pin_q;

  // ----------------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------------
  edge_if trig_e ();
  edge_if cap_e ();
  assign trig_e.pin_in = ext_trigger_pin;
  assign cap_e.pin_in  = capture_in_pin;

  pin_edge_sync u_trig (.sys_clk(sys_clk), .rst_n(rst_n), .e(trig_e));
  pin_edge_sync u_cap  (.sys_clk(sys_clk), .rst_n(rst_n), .e(cap_e));

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  assign mode     = {mode_sel_hi, mode_sel_lo};
  assign io       = {out_ctrl_hi, out_ctrl_lo};
  assign sp_mode  = (mode == timer_pkg::MODE_PWM) && (io == timer_pkg::PWM_SINGLE);
  assign pwm_mode = (mode == timer_pkg::MODE_PWM) && !sp_mode;
  assign cap_mode = (mode == timer_pkg::MODE_CAP);
  assign cmp_mode = (mode == timer_pkg::MODE_CMP) || (mode == timer_pkg::MODE_TMR);

  // ----------------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------------
  assign cnt_inc  = cnt_q + CNT_ONE;
  assign run_rise = run_q & ~run_prev_q;
  assign a_match  = tick && run_q && !run_rise && (cnt_inc == compare_a_value_q);
  // p of zero means the natural overflow at full count
  assign p_match  = tick && run_q && !run_rise &&
                    ((compare_p_value == '0) ? (cnt_q == CNT_MAX) : (cnt_inc == p_full(compare_p_value)));

  // counter clear source per mode
  always_comb begin
    clr_now = 1'b0;
    if (pwm_mode) begin
      clr_now = duty_period_swap ? a_match : p_match;
    end else if (cap_mode) begin
      clr_now = p_match;
    end else if (cmp_mode) begin
      clr_now = clear_source_sel ? a_match : p_match;
    end
  end

  // capture edge select; 11 blocks capture
  always_comb begin
    unique case (io)
      timer_pkg::CAP_RISE: cap_evt = cap_mode && cap_e.rise;
      timer_pkg::CAP_FALL: cap_evt = cap_mode && cap_e.fall;
      timer_pkg::CAP_BOTH: cap_evt = cap_mode && (cap_e.rise || cap_e.fall);
      timer_pkg::CAP_OFF:  cap_evt = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // run bit and counter
  // ----------------------------------------------------------------------
  // software write first, hardware set beats hardware clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
    end else if (run_wr) begin
      run_q <= run_wdata;
    end else if (sp_mode && trig_e.rise) begin
      run_q <= 1'b1;
    end else if (sp_mode && a_match) begin
      run_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= run_q;
    end
  end

  // single pulse mode never clears except at run rise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (run_rise) begin
      cnt_q <= '0;
    end else if (tick && run_q) begin
      if (clr_now && !sp_mode) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_inc;
      end
    end
  end

  // capture wins over a software write in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_a_value_q <= '0;
    end else if (cap_evt) begin
      compare_a_value_q <= cnt_q;
    end else if (a_wr) begin
      compare_a_value_q <= a_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt request flags
  // ----------------------------------------------------------------------
  assign set_a = cap_mode ? cap_evt : a_match;
  assign set_p = p_match && !sp_mode && !(cmp_mode && clear_source_sel);

  // sticky; a set in the clear cycle is kept
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_a_q <= 1'b0;
      flag_p_q <= 1'b0;
    end else begin
      flag_a_q <= set_a | (flag_a_q & ~flag_a_clr);
      flag_p_q <= set_p | (flag_p_q & ~flag_p_clr);
    end
  end

  // ----------------------------------------------------------------------
  // output waveform
  // ----------------------------------------------------------------------
  assign duty_act = duty_period_swap ?
                    ((compare_p_value == '0) || (cnt_q < p_full(compare_p_value))) :
                    (cnt_q < compare_a_value_q);

  always_comb begin
    lvl_d = lvl_q;
    if (sp_mode) begin
      lvl_d = run_q ? out_initial_level : ~out_initial_level;
    end else if (pwm_mode) begin
      unique case (io)
        timer_pkg::PWM_FORCE_LOW:  lvl_d = 1'b0;
        timer_pkg::PWM_FORCE_HIGH: lvl_d = 1'b1;
        default:                   lvl_d = duty_act ? out_initial_level : ~out_initial_level;
      endcase
    end else if (cmp_mode) begin
      if (run_rise) begin
        lvl_d = out_initial_level;
      end else if (a_match) begin
        unique case (io)
          timer_pkg::IO_NONE:   lvl_d = lvl_q;
          timer_pkg::IO_LOW:    lvl_d = 1'b0;
          timer_pkg::IO_HIGH:   lvl_d = 1'b1;
          timer_pkg::IO_TOGGLE: lvl_d = ~lvl_q;
        endcase
      end
    end
  end

  // registered pin; capture and timer modes leave it idle low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      pin_q <= (cap_mode || mode == timer_pkg::MODE_TMR) ? 1'b0 : (lvl_d ^ out_polarity);
    end
  end

  assign timer_out_pin   = pin_q;
  assign timer_out_oe    = (mode == timer_pkg::MODE_CMP) || (mode == timer_pkg::MODE_PWM);
  assign counter_run     = run_q;
  assign compare_a_value = compare_a_value_q;
  assign count_value     = cnt_q;
  assign cmp_a_irq_flag  = flag_a_q;
  assign cmp_p_irq_flag  = flag_p_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_SP_TRIGGER_SETS_RUN: assert property (
    sp_mode && trig_e.rise && !run_wr && !run_q |=> run_q ##1 (cnt_q == '0))
    else $error("trigger edge did not start single pulse");
  AST_SP_A_ENDS_PULSE: assert property (
    sp_mode && a_match && !run_wr && !trig_e.rise |=> !run_q)
    else $error("A match did not clear run bit");
  AST_SP_A_FLAG: assert property (
    sp_mode && a_match |=> cmp_a_irq_flag)
    else $error("A match did not raise A flag");
  AST_SP_PIN_LEVEL: assert property (
    sp_mode && run_q |=> timer_out_pin == ($past(out_initial_level) ^ $past(out_polarity)))
    else $error("single pulse pin level wrong");
  AST_SP_NO_CLEAR: assert property (
    sp_mode && !run_rise && tick && run_q |=> cnt_q == $past(cnt_inc))
    else $error("single pulse counter cleared outside run rise");
  AST_RUN_RISE_ZERO: assert property (
    run_rise |=> cnt_q == '0)
    else $error("counter not zeroed at run rise");
  AST_CAPTURE_COPY: assert property (
    cap_evt |=> (compare_a_value_q == $past(cnt_q)) && cmp_a_irq_flag)
    else $error("capture did not latch counter");
  AST_CAPTURE_OFF: assert property (
    cap_mode && io == timer_pkg::CAP_OFF && !a_wr |=> $stable(compare_a_value_q))
    else $error("capture with control 11");
  AST_CAP_P_WRAP: assert property (
    cap_mode && p_match |=> (cnt_q == '0) && cmp_p_irq_flag)
    else $error("P match did not wrap capture counter");
  AST_PWM_SWAP_CLEAR: assert property (
    pwm_mode && duty_period_swap && a_match |=> cnt_q == '0)
    else $error("A match did not clear pwm counter");
  AST_HOLD_STOPPED: assert property (
    !run_q |=> $stable(cnt_q))
    else $error("counter moved while stopped");
  AST_CAP_NO_OUTPUT: assert property (
    cap_mode |=> !timer_out_pin)
    else $error("pin driven in capture mode");

  COV_SINGLE_PULSE: cover property (sp_mode && trig_e.rise ##[1:300] sp_mode && a_match);
  COV_CAPTURE: cover property (cap_mode && run_q ##[1:100] cap_evt);
  COV_PWM_PERIOD: cover property (pwm_mode && clr_now ##[1:300] pwm_mode && clr_now);
endmodule

// ----------------------------------------------------------------------
// top: shared tick divider and the two timer instances
// ----------------------------------------------------------------------
module timer_pulse_capture_modes (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // tick rate select, shared
  input  wire logic [1:0]                    clk_div_sel,
  // per-instance control bits, index 0 = 10-bit, 1 = 16-bit
  input  wire logic [1:0]                    mode_sel_hi,
  input  wire logic [1:0]                    mode_sel_lo,
  input  wire logic [1:0]                    out_ctrl_hi,
  input  wire logic [1:0]                    out_ctrl_lo,
  input  wire logic [1:0]                    clear_source_sel,
  input  wire logic [1:0]                    duty_period_swap,
  input  wire logic [1:0]                    out_initial_level,
  input  wire logic [1:0]                    out_polarity,
  input  wire logic [1:0]                    run_wr,
  input  wire logic [1:0]                    run_wdata,
  input  wire logic [1:0]                    a_wr,
  input  wire logic [1:0]                    flag_a_clr,
  input  wire logic [1:0]                    flag_p_clr,
  // comparator values
  input  wire logic [timer_pkg::CNT_W0-1:0]  a_wdata_u0,
  input  wire logic [timer_pkg::CNT_W1-1:0]  a_wdata_u1,
  input  wire logic [timer_pkg::PW0-1:0]     compare_p_value_u0,
  input  wire logic [timer_pkg::PW1-1:0]     compare_p_value_u1,
  // pins
  input  wire logic [1:0]                    ext_trigger_pin,
  input  wire logic [1:0]                    capture_in_pin,
  output logic [1:0]                         timer_out_pin,
  output logic [1:0]                         timer_out_oe,
  // status
  output logic [1:0]                         counter_run,
  output logic [1:0]                         cmp_a_irq_flag,
  output logic [1:0]                         cmp_p_irq_flag,
  output logic [timer_pkg::CNT_W0-1:0]       compare_a_value_u0,
  output logic [timer_pkg::CNT_W1-1:0]       compare_a_value_u1,
  output logic [timer_pkg::CNT_W0-1:0]       count_value_u0,
  output logic [timer_pkg::CNT_W1-1:0]       count_value_u1
);
  logic [timer_pkg::DIV_W-1:0] div_q;
  logic [timer_pkg::DIV_W-1:0] div_mask;
  logic                        tick;

  // free running prescaler; one-cycle tick enable, no derived clocks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + timer_pkg::DIV_STEP;
    end
  end

  always_comb begin
    unique case (clk_div_sel)
      timer_pkg::DIV_SEL_1:  div_mask = timer_pkg::DIV_MASK_1;
      timer_pkg::DIV_SEL_4:  div_mask = timer_pkg::DIV_MASK_4;
      timer_pkg::DIV_SEL_16: div_mask = timer_pkg::DIV_MASK_16;
      default:               div_mask = timer_pkg::DIV_MASK_64;
    endcase
  end

  assign tick = (div_q & div_mask) == '0;

  // 10-bit and 16-bit instances
  timer_core #(.CNT_W(timer_pkg::CNT_W0), .PW(timer_pkg::PW0)) u_tm0 (
    .sys_clk(sys_clk), .rst_n(rst_n), .tick(tick),
    .mode_sel_hi(mode_sel_hi[0]), .mode_sel_lo(mode_sel_lo[0]),
    .out_ctrl_hi(out_ctrl_hi[0]), .out_ctrl_lo(out_ctrl_lo[0]),
    .clear_source_sel(clear_source_sel[0]), .duty_period_swap(duty_period_swap[0]),
    .out_initial_level(out_initial_level[0]), .out_polarity(out_polarity[0]),
    .run_wr(run_wr[0]), .run_wdata(run_wdata[0]), .a_wr(a_wr[0]), .a_wdata(a_wdata_u0),
    .compare_p_value(compare_p_value_u0), .flag_a_clr(flag_a_clr[0]), .flag_p_clr(flag_p_clr[0]),
    .ext_trigger_pin(ext_trigger_pin[0]), .capture_in_pin(capture_in_pin[0]),
    .timer_out_pin(timer_out_pin[0]), .timer_out_oe(timer_out_oe[0]),
    .counter_run(counter_run[0]), .compare_a_value(compare_a_value_u0), .count_value(count_value_u0),
    .cmp_a_irq_flag(cmp_a_irq_flag[0]), .cmp_p_irq_flag(cmp_p_irq_flag[0])
  );

  timer_core #(.CNT_W(timer_pkg::CNT_W1), .PW(timer_pkg::PW1)) u_tm1 (
    .sys_clk(sys_clk), .rst_n(rst_n), .tick(tick),
    .mode_sel_hi(mode_sel_hi[1]), .mode_sel_lo(mode_sel_lo[1]),
    .out_ctrl_hi(out_ctrl_hi[1]), .out_ctrl_lo(out_ctrl_lo[1]),
    .clear_source_sel(clear_source_sel[1]), .duty_period_swap(duty_period_swap[1]),
    .out_initial_level(out_initial_level[1]), .out_polarity(out_polarity[1]),
    .run_wr(run_wr[1]), .run_wdata(run_wdata[1]), .a_wr(a_wr[1]), .a_wdata(a_wdata_u1),
    .compare_p_value(compare_p_value_u1), .flag_a_clr(flag_a_clr[1]), .flag_p_clr(flag_p_clr[1]),
    .ext_trigger_pin(ext_trigger_pin[1]), .capture_in_pin(capture_in_pin[1]),
    .timer_out_pin(timer_out_pin[1]), .timer_out_oe(timer_out_oe[1]),
    .counter_run(counter_run[1]), .compare_a_value(compare_a_value_u1), .count_value(count_value_u1),
    .cmp_a_irq_flag(cmp_a_irq_flag[1]), .cmp_p_irq_flag(cmp_p_irq_flag[1])
  );
endmodule
`default_nettype wire

/* verification/pin_partner.sv */
// pin-side model: trigger pulses and capture pin level changes
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  // clock
  input  wire logic       sys_clk,
  // one-cycle requests from the bench
  input  wire logic [1:0] trig_req,
  input  wire logic [1:0] cap_req,
  // pins toward the timer
  output logic [1:0]      ext_trigger_pin,
  output logic [1:0]      capture_in_pin
);
  logic [2:0] hold_q [2];
  initial begin
    ext_trigger_pin = 2'h0;
    capture_in_pin  = 2'h0;
    hold_q[0]       = 3'h0;
    hold_q[1]       = 3'h0;
  end
  // trigger held several cycles, long enough for the two-flop synchroniser
  always @(posedge sys_clk) begin
    for (int u = 0; u < 2; u++) begin
      if (trig_req[u]) hold_q[u] <= 3'h6;
      else if (hold_q[u] != 3'h0) hold_q[u] <= hold_q[u] - 3'h1;
      ext_trigger_pin[u] <= trig_req[u] || (hold_q[u] > 3'h1);
      if (cap_req[u]) capture_in_pin[u] <= ~capture_in_pin[u];
    end
  end
endmodule
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the timer pair
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 0, rst_n = 0;
  logic [1:0] md_h = 0, md_l = 0, io_h = 0, io_l = 0, ccs = 0, swp = 0, oil = 0, pol = 0;
  logic [1:0] run_wr = 0, run_wd = 0, a_wr = 0, fa_clr = 0, fp_clr = 0, trig_req = 0, cap_req = 0;
  logic [9:0] a_u0 = 0;
  logic [15:0] a_u1 = 0, meas = 0;
  logic [2:0] p_u0 = 0;
  logic [7:0] p_u1 = 0;
  logic [1:0] dsel = 0;
  logic [1:0] trg, cap, pin, oe, run, fa, fp;
  logic [9:0] ca0, cn0;
  logic [15:0] ca1, cn1;
  int n_errors = 0, tests_run = 0, seed = 90;
  typedef struct {string nm; int s; int u; logic [15:0] exp;} note_t;
  note_t notes[$];
  event probe, done;
  pin_partner pp (.sys_clk(sys_clk), .trig_req(trig_req), .cap_req(cap_req), .ext_trigger_pin(trg),
    .capture_in_pin(cap));
  timer_pulse_capture_modes dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_div_sel(dsel), .mode_sel_hi(md_h),
    .mode_sel_lo(md_l), .out_ctrl_hi(io_h), .out_ctrl_lo(io_l), .clear_source_sel(ccs), .duty_period_swap(swp),
    .out_initial_level(oil), .out_polarity(pol), .run_wr(run_wr), .run_wdata(run_wd), .a_wr(a_wr),
    .flag_a_clr(fa_clr), .flag_p_clr(fp_clr), .a_wdata_u0(a_u0), .a_wdata_u1(a_u1), .compare_p_value_u0(p_u0),
    .compare_p_value_u1(p_u1), .ext_trigger_pin(trg), .capture_in_pin(cap), .timer_out_pin(pin),
    .timer_out_oe(oe), .counter_run(run), .cmp_a_irq_flag(fa), .cmp_p_irq_flag(fp), .compare_a_value_u0(ca0),
    .compare_a_value_u1(ca1), .count_value_u0(cn0), .count_value_u1(cn1));
  initial forever #4 sys_clk = ~sys_clk;
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task cmp(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [15:0] seen(input int s, input int u);
    case (s)
      0: return 16'(run[u]);
      1: return 16'(fa[u]);
      2: return 16'(fp[u]);
      3: return 16'(pin[u]);
      4: return 16'(oe[u]);
      default: return meas;
    endcase
  endfunction
  // watcher: oldest note against what the outputs show now
  always @(probe) begin
    while (notes.size() > 0) begin
      cmp(notes[0].nm, seen(notes[0].s, notes[0].u), notes[0].exp);
      void'(notes.pop_front());
    end
    -> done;
  end
  task note(input string nm, input int s, input int u, input logic [15:0] exp);
    @(negedge sys_clk);
    notes.push_back('{nm, s, u, exp});
    -> probe;
    // hold the driver until the watcher has compared, so meas is not overwritten
    @(done);
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // one-cycle strobes: 0 run write, 1 A write, 2 flag clear, 3 trigger, 4 capture toggle
  task pulse(input int k, input int u, input logic [15:0] v);
    @(posedge sys_clk);
    case (k)
      0: begin run_wr[u] <= 1'h1; run_wd[u] <= v[0]; end
      1: begin a_wr <= 2'h3; a_u0 <= v[9:0]; a_u1 <= v; end
      2: begin fa_clr[u] <= 1'h1; fp_clr[u] <= 1'h1; end
      3: trig_req[u] <= 1'h1;
      default: cap_req[u] <= 1'h1;
    endcase
    @(posedge sys_clk);
    {run_wr, a_wr, fa_clr, fp_clr, trig_req, cap_req} <= 12'h0;
  endtask
  // clear source is random in every mode, swap only in capture mode, which ignores it
  task cfg(input int u, input logic [1:0] m, input logic [1:0] io);
    @(posedge sys_clk);
    {md_h[u], md_l[u]} <= m;
    {io_h[u], io_l[u]} <= io;
    ccs[u] <= 1'($random(seed));
    if (m == timer_pkg::MODE_CAP) swp[u] <= 1'($random(seed));
  endtask
  task duty(input int n);
    meas = 0;
    repeat (n) begin
      @(negedge sys_clk);
      meas = meas + 16'(pin[0]);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(5);
    rst_n <= 1'h1;
    // pwm, 10-bit unit: period 128 ticks from P=1, active for 32
    p_u0 <= 3'h1;
    oil <= 2'h3;
    pulse(1, 0, 16'h0020);
    cfg(0, timer_pkg::MODE_PWM, timer_pkg::PWM_WAVE);
    pulse(0, 0, 16'h1);
    cyc(300);
    duty(256);
    note("pwm duty", 7, 0, 16'h0040);
    pulse(1, 0, 16'h00c8);
    swp[0] <= 1'h1;
    cyc(450);
    duty(400);
    note("swap duty", 7, 0, 16'h0100);
    @(posedge sys_clk);
    pol[0] <= 1'h1;
    cyc(10);
    duty(400);
    note("inverted duty", 7, 0, 16'h0090);
    cfg(0, timer_pkg::MODE_PWM, timer_pkg::PWM_FORCE_LOW);
    cyc(4);
    duty(100);
    note("forced pin", 7, 0, 16'h0064);
    meas = 16'(cn0);
    repeat (7) @(negedge sys_clk);
    meas = 16'(meas[9:0] != cn0);
    note("pwm counting", 7, 0, 16'h1);
    pulse(0, 0, 16'h0);
    $display("pwm test done");
    // single pulse, 16-bit unit, width 20 ticks from A
    pol[0] <= 1'h0;
    p_u1 <= 8'($random(seed));
    swp[1] <= 1'($random(seed));
    pulse(1, 1, 16'h0014);
    cfg(1, timer_pkg::MODE_PWM, timer_pkg::PWM_SINGLE);
    cyc(4);
    note("idle pin", 3, 1, 16'h0);
    pulse(3, 1, 16'h0);
    cyc(8);
    note("trigger run", 0, 1, 16'h1);
    note("lead edge", 3, 1, 16'h1);
    cyc(30);
    note("a stop", 0, 1, 16'h0);
    note("a flag", 1, 1, 16'h1);
    note("trail edge", 3, 1, 16'h0);
    meas = ca1;
    note("pulse width reg", 7, 1, 16'h0014);
    note("p ignored", 2, 1, 16'h0);
    note("sp oe", 4, 1, 16'h1);
    pulse(0, 1, 16'h1);
    cyc(3);
    @(negedge sys_clk);
    meas = 16'(cn1 < 16'h0008);
    note("restart zero", 7, 1, 16'h1);
    pulse(0, 1, 16'h0);
    cyc(2);
    note("sw trail", 3, 1, 16'h0);
    $display("single pulse test done");
    // capture, 10-bit unit, P=0 runs the full count
    @(posedge sys_clk);
    p_u0 <= 3'h0;
    cfg(0, timer_pkg::MODE_CAP, timer_pkg::CAP_RISE);
    pulse(0, 0, 16'h1);
    cyc(49);
    pulse(4, 0, 16'h0);
    cyc(6);
    meas = 16'(ca0 > 10'h031 && ca0 < 10'h039);
    note("captured count", 7, 0, 16'h1);
    note("cap oe", 4, 0, 16'h0);
    note("cap run", 0, 0, 16'h1);
    pulse(4, 0, 16'h0);
    for (int i = 0; i < 4; i++) begin
      cfg(0, timer_pkg::MODE_CAP, 2'(i));
      cyc(6);
      pulse(2, 0, 16'h0);
      pulse(4, 0, 16'h0);
      cyc(6);
      note("cap rise", 1, 0, 16'(i == 0 || i == 2));
      pulse(2, 0, 16'h0);
      pulse(4, 0, 16'h0);
      cyc(6);
      note("cap fall", 1, 0, 16'(i == 1 || i == 2));
    end
    note("no early wrap", 2, 0, 16'h0);
    cyc(1000);
    note("full wrap", 2, 0, 16'h1);
    @(posedge sys_clk);
    p_u0 <= 3'h1;
    pulse(0, 0, 16'h0);
    pulse(0, 0, 16'h1);
    pulse(2, 0, 16'h0);
    cyc(140);
    @(negedge sys_clk);
    meas = 16'(cn0 < 10'h080);
    note("p wrap", 2, 0, 16'h1);
    note("p top", 7, 0, 16'h1);
    $display("capture test done");
    // compare mode toggling on A, tick every fourth cycle, then timer mode
    pulse(0, 0, 16'h0);
    cfg(0, timer_pkg::MODE_CMP, timer_pkg::IO_TOGGLE);
    ccs[0] <= 1'h1;
    dsel <= 2'h1;
    pulse(1, 0, 16'h0010);
    pulse(0, 0, 16'h1);
    pulse(2, 0, 16'h0);
    cyc(150);
    duty(256);
    note("toggle duty", 7, 0, 16'h0080);
    note("a flag cmp", 1, 0, 16'h1);
    cfg(0, timer_pkg::MODE_TMR, timer_pkg::IO_TOGGLE);
    pol[0] <= 1'h1;
    cyc(4);
    duty(64);
    note("timer pin", 7, 0, 16'h0);
    note("timer oe", 4, 0, 16'h0);
    $display("compare test done");
    complete_run();
  end
  // hang guard, well past the roughly 4000 cycles the tests need
  initial begin
    #(8 * 20000);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
